// >>> rtl/awd_defines.svh
// Purpose: Constants for the converter window detector.
// Assumes: Byte-wide register port, 16-bit result word.
// Notes: Offsets index the local register port.
`ifndef AWD_DEFINES_SVH
`define AWD_DEFINES_SVH
`define AWD_OFS_UPPER_HIGH 2'h0
`define AWD_OFS_UPPER_LOW 2'h1
`define AWD_OFS_LOWER_HIGH 2'h2
`define AWD_OFS_LOWER_LOW 2'h3
`define AWD_UPPER_RESET 8'h00
`define AWD_LOWER_RESET 8'hff
`define AWD_SIGN_RIGHT 9
`define AWD_SIGN_LEFT 15
`endif

// >>> rtl/awd_pkg.sv
// Purpose: Types for the converter window detector.
// Assumes: Nothing beyond the defines header.
// Notes: One-hot compare sequencer states.
package awd_pkg;
	typedef enum logic [1:0] {
		AWD_IDLE = 2'b01,
		AWD_EVAL = 2'b10
	} awd_state_t;
endpackage : awd_pkg

// >>> rtl/awd_limit_regs.sv
// Purpose: Four byte-wide limit registers with registered read data.
// Assumes: Synchronous write and read strobes.
// Notes: Lower limit resets to all ones, upper limit to zero.
`timescale 1ns/1ps
`include "awd_defines.svh"
module awd_limit_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [1:0] addr,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	output logic [15:0] upperWord,
	output logic [15:0] lowerWord
);
	logic [7:0] regs [4];
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_reg
			always_ff @(posedge clk) begin
				if (srst) begin
					regs[i] <= (i < 2) ? `AWD_UPPER_RESET : `AWD_LOWER_RESET;
				end else if (wrEn && addr == 2'(i)) begin
					regs[i] <= wrData;
				end
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (srst) begin
			rdData <= 8'h00;
		end else if (rdEn) begin
			rdData <= regs[addr];
		end
	end
	assign upperWord = {regs[`AWD_OFS_UPPER_HIGH], regs[`AWD_OFS_UPPER_LOW]};
	assign lowerWord = {regs[`AWD_OFS_LOWER_HIGH], regs[`AWD_OFS_LOWER_LOW]};
endmodule : awd_limit_regs

// >>> rtl/awd_window_detector.sv
// Purpose: Compare each new conversion word against two limit words.
// Assumes: resultValid pulses once per finished conversion.
// Notes: Flag is sticky; hardware set wins over software clear.
// Contract
// R1: Single-ended results and limits compare as unsigned values.
// R2: Inside window flags only strictly between lower and upper limit.
// R3: Outside window flags strictly below upper or above lower limit.
// R4: Differential results compare as two's complement signed values.
// R5: Differential limit 0xFFFF means minus one in inside window.
// R6: Differential outside window uses signed ordering too.
// R7: Left-justified words compare with limits in same justification.
// R8: Every new result is compared without processor help.
// R9: Flag drives an interrupt line and is readable by polling.
// R10: Upper above lower selects inside, otherwise outside detection.
`timescale 1ns/1ps
`include "awd_defines.svh"
module awd_window_detector (
	input wire logic clk,
	input wire logic srst,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic [15:0] resultWord,
	input wire logic resultValid,
	input wire logic differentialMode,
	input wire logic leftJustified,
	input wire logic flagClear,
	output logic windowMatchFlag,
	output logic windowIrq
);
	logic [15:0] upperWord;
	logic [15:0] lowerWord;
	logic [15:0] heldResult;
	logic [16:0] resX;
	logic [16:0] upX;
	logic [16:0] loX;
	logic aboveLower;
	logic belowUpper;
	logic insideMode;
	logic hit;
	awd_pkg::awd_state_t state;
	awd_pkg::awd_state_t next_state;

	awd_limit_regs u_regs (
		.clk(clk),
		.srst(srst),
		.wrEn(regWrEn),
		.rdEn(regRdEn),
		.addr(regAddr),
		.wrData(regWrData),
		.rdData(regRdData),
		.upperWord(upperWord),
		.lowerWord(lowerWord)
	);

	// Sign extension to 17 bits lets one signed compare serve all modes;
	// right-justified words carry sign at bit 9, left at bit 15.
	function automatic logic [16:0] awd_ext(input logic [15:0] w,
			input logic diff, input logic left);
		logic s;
		s = 1'b0;
		if (diff) begin // R4 R5 R6
			s = left ? w[`AWD_SIGN_LEFT] : w[`AWD_SIGN_RIGHT];
		end
		if (!left && diff) begin // R7
			awd_ext = {{7{s}}, w[9:0]};
		end else begin
			awd_ext = {s, w};
		end
	endfunction : awd_ext

	always_comb begin
		resX = awd_ext(heldResult, differentialMode, leftJustified); // R1
		upX = awd_ext(upperWord, differentialMode, leftJustified);
		loX = awd_ext(lowerWord, differentialMode, leftJustified);
		aboveLower = $signed(resX) > $signed(loX);
		belowUpper = $signed(resX) < $signed(upX);
		insideMode = $signed(upX) > $signed(loX); // R10
		if (insideMode) begin
			hit = aboveLower && belowUpper; // R2 R5
		end else begin
			// Strictly outside: below smaller limit or above larger one
			hit = ($signed(resX) < $signed(upX)) ||
				($signed(resX) > $signed(loX)); // R3 R6
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			heldResult <= 16'h0000;
		end else if (resultValid) begin
			heldResult <= resultWord; // R8
		end
	end

	always_comb begin
		case (state)
			awd_pkg::AWD_IDLE: next_state = resultValid ?
				awd_pkg::AWD_EVAL : awd_pkg::AWD_IDLE;
			awd_pkg::AWD_EVAL: next_state = resultValid ?
				awd_pkg::AWD_EVAL : awd_pkg::AWD_IDLE;
			default: next_state = awd_pkg::AWD_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= awd_pkg::AWD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			windowMatchFlag <= 1'b0;
		end else if (state == awd_pkg::AWD_EVAL && hit) begin
			windowMatchFlag <= 1'b1; // R8 R9
		end else if (flagClear) begin
			windowMatchFlag <= 1'b0;
		end
	end

	assign windowIrq = windowMatchFlag; // R9

	a_flag_sets: assert property (@(posedge clk) disable iff (srst) // R8
		state == awd_pkg::AWD_EVAL && hit |=> windowMatchFlag)
		else $error("match not flagged");
	a_flag_holds: assert property (@(posedge clk) disable iff (srst) // R9
		windowMatchFlag && !flagClear |=> windowMatchFlag)
		else $error("flag dropped without clear");
	a_flag_cause: assert property (@(posedge clk) disable iff (srst) // R8
		$rose(windowMatchFlag) |-> $past(state) == awd_pkg::AWD_EVAL)
		else $error("flag set without compare");
	a_irq_follows: assert property (@(posedge clk) disable iff (srst) // R9
		windowIrq == windowMatchFlag)
		else $error("irq differs from flag");
	a_inside_hit: assert property (@(posedge clk) disable iff (srst) // R2
		insideMode && hit |-> aboveLower && belowUpper)
		else $error("inside hit outside window");
	// Checked against the closed span so an off-by-one compare shows up
	a_outside_hit: assert property (@(posedge clk) disable iff (srst) // R3
		!insideMode && hit |-> !($signed(resX) >= $signed(upX) &&
		$signed(resX) <= $signed(loX)))
		else $error("outside hit inside window");
	a_unsigned_se: assert property (@(posedge clk) disable iff (srst) // R1
		!differentialMode |-> !resX[16] && !upX[16] && !loX[16])
		else $error("single-ended value signed");
	a_diff_sign: assert property (@(posedge clk) disable iff (srst) // R4
		differentialMode && !leftJustified |->
		resX[16] == heldResult[9])
		else $error("sign not from bit 9");
	a_mode_pick: assert property (@(posedge clk) disable iff (srst) // R10
		!differentialMode && upperWord > lowerWord |-> insideMode)
		else $error("inside mode not chosen");

	// The flag trails a result by two edges: taken, judged, then latched
	sequence s_result_taken;
		resultValid ##1 state == awd_pkg::AWD_EVAL;
	endsequence : s_result_taken

	sequence s_judged_hit;
		s_result_taken ##0 hit;
	endsequence : s_judged_hit

	sequence s_judged_miss;
		s_result_taken ##0 !hit ##0 !flagClear;
	endsequence : s_judged_miss

	property p_hit_latches;
		@(posedge clk) disable iff (srst)
		s_judged_hit |=> windowMatchFlag;
	endproperty : p_hit_latches

	// A miss never clears a pending match; only software may do that
	property p_miss_keeps;
		@(posedge clk) disable iff (srst)
		s_judged_miss |=> windowMatchFlag == $past(windowMatchFlag);
	endproperty : p_miss_keeps

	a_hit_latches: assert property (p_hit_latches) // R8
		else $error("judged hit not latched");
	a_miss_keeps: assert property (p_miss_keeps) // R9
		else $error("miss changed the flag");
	a_taken_eval: assert property (@(posedge clk) disable iff (srst) // R8
		resultValid |=> state == awd_pkg::AWD_EVAL)
		else $error("result not judged");
	a_eval_ends: assert property (@(posedge clk) disable iff (srst) // R8
		!resultValid |=> state == awd_pkg::AWD_IDLE)
		else $error("judged without result");
	a_state_onehot: assert property (@(posedge clk) disable iff (srst) // R8
		$onehot(state))
		else $error("state not one-hot");
	a_held_word: assert property (@(posedge clk) disable iff (srst) // R8
		resultValid |=> heldResult == $past(resultWord))
		else $error("result word not held");
	// Set must win: a clear racing a match would lose an event
	a_set_wins: assert property (@(posedge clk) disable iff (srst) // R9
		state == awd_pkg::AWD_EVAL && hit && flagClear |=> windowMatchFlag)
		else $error("clear beat a match");
	a_clear_drops: assert property (@(posedge clk) disable iff (srst) // R9
		flagClear && !(state == awd_pkg::AWD_EVAL && hit) |=>
		!windowMatchFlag)
		else $error("clear ignored");
	a_reset_values: assert property (@(posedge clk) srst |=> // R10
		!windowMatchFlag && regRdData == 8'h00 &&
		upperWord == {2{`AWD_UPPER_RESET}} &&
		lowerWord == {2{`AWD_LOWER_RESET}})
		else $error("reset values wrong");
	a_left_sign: assert property (@(posedge clk) disable iff (srst) // R7
		differentialMode && leftJustified |->
		resX[16] == heldResult[15])
		else $error("sign not from bit 15");
	a_se_zero_ext: assert property (@(posedge clk) disable iff (srst) // R1
		!differentialMode |-> resX[15:0] == heldResult)
		else $error("single-ended word altered");
	// Reads return the byte as it stood before a same-edge write
	a_rd_upper: assert property (@(posedge clk) disable iff (srst) // R10
		regRdEn && regAddr == `AWD_OFS_UPPER_HIGH |=>
		regRdData == $past(upperWord[15:8]))
		else $error("upper limit read wrong");
	a_rd_lower: assert property (@(posedge clk) disable iff (srst) // R10
		regRdEn && regAddr == `AWD_OFS_LOWER_LOW |=>
		regRdData == $past(lowerWord[7:0]))
		else $error("lower limit read wrong");
endmodule : awd_window_detector

// >>> sim/awd_result_src.sv
// Purpose: Converter result source facing the window detector.
// Assumes: send is raised just after a clock edge for one cycle.
// Notes: Word bus is scrambled between results so stale data never hits.
`timescale 1ns/1ps
module awd_result_src (
	input wire logic send,
	input wire logic [15:0] word,
	output logic [15:0] resultWord,
	output logic resultValid
);
	assign resultValid = send;
	assign resultWord = send ? word : ~word;
endmodule : awd_result_src

// >>> sim/adc_window_detector_limits_tb.sv
// Purpose: Self-checking bench for the converter window detector.
// Assumes: Flag settles one edge after the result edge.
// Notes: Limits are written as four back-to-back byte writes.
`timescale 1ns/1ps
module adc_window_detector_limits_tb;
	logic clk = 0, srst = 1, wrEn = 0, rdEn = 0, send = 0;
	logic diff = 0, left = 0, clr = 0, resultValid, flag, irq;
	logic [1:0] addr = 2'h0;
	logic [7:0] wrData = 8'h00, rdData;
	logic [15:0] word = 16'h0000, resultWord;
	int errorCnt = 0, nCompared = 0;
	always #12.5 clk = ~clk;
	awd_result_src u_src (.send(send), .word(word),
		.resultWord(resultWord), .resultValid(resultValid));
	awd_window_detector u_dut (.clk(clk), .srst(srst), .regWrEn(wrEn),
		.regRdEn(rdEn), .regAddr(addr), .regWrData(wrData),
		.regRdData(rdData), .resultWord(resultWord),
		.resultValid(resultValid), .differentialMode(diff),
		.leftJustified(left), .flagClear(clr),
		.windowMatchFlag(flag), .windowIrq(irq));
	task step;
		@(posedge clk);
		#2;
	endtask : step
	task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		nCompared++;
		if (got !== exp) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task lim(input logic [15:0] up, input logic [15:0] lo);
		logic [7:0] b[4];
		b = '{up[15:8], up[7:0], lo[15:8], lo[7:0]};
		wrEn = 1;
		for (int i = 0; i < 4; i++) begin
			addr = i[1:0];
			wrData = b[i];
			step();
		end
		wrEn = 0;
	endtask : lim
	task rd(input logic [1:0] a, input logic [7:0] exp);
		addr = a;
		rdEn = 1;
		step();
		rdEn = 0;
		cmp("rdData", exp, rdData);
		// Idle edge keeps the strobe low between two reads
		step();
	endtask : rd
	// Clear comes a cycle after the check so it never meets a new hit
	task chk(input logic [15:0] w, input logic exp);
		word = w;
		send = 1;
		step();
		send = 0;
		repeat (2) step();
		cmp("flag irq", {6'h0, exp, exp}, {6'h0, flag, irq});
		clr = 1;
		step();
		clr = 0;
	endtask : chk
	task tally_and_finish;
		$display("compared %0d mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) step();
		srst = 0;
		rd(2'h0, 8'h00);
		rd(2'h2, 8'hff);
		lim(16'h0280, 16'h0040);
		rd(2'h1, 8'h80);
		rd(2'h0, 8'h02);
		rd(2'h2, 8'h00);
		rd(2'h3, 8'h40);
		chk(16'h0200, 1);
		lim(16'h0080, 16'h0040);
		chk(16'h0041, 1);
		chk(16'h0040, 0);
		chk(16'h0080, 0);
		lim(16'h0040, 16'h0080);
		chk(16'h003f, 1);
		chk(16'h0040, 0);
		chk(16'h0081, 1);
		diff = 1;
		lim(16'h0040, 16'hffff);
		chk(16'h0000, 1);
		chk(16'hffff, 0);
		chk(16'hfffe, 0);
		lim(16'hffff, 16'h0040);
		chk(16'hfffe, 1);
		chk(16'h0041, 1);
		chk(16'h0000, 0);
		diff = 0;
		left = 1;
		lim(16'h2000, 16'h1000);
		chk(16'h1040, 1);
		chk(16'h2040, 0);
		diff = 1;
		lim(16'h1000, 16'hffc0);
		chk(16'h0000, 1);
		chk(16'hffc0, 0);
		chk(16'h1000, 0);
		// Hit and clear judged in one cycle: the hit must win
		word = 16'h0000;
		send = 1;
		step();
		send = 0;
		clr = 1;
		step();
		clr = 0;
		cmp("flag set wins", 8'h01, {7'h00, flag});
		word = 16'h2000;
		send = 1;
		step();
		send = 0;
		repeat (2) step();
		cmp("flag sticky", 8'h01, {7'h00, flag});
		clr = 1;
		step();
		clr = 0;
		cmp("flag cleared", 8'h00, {7'h00, flag});
		// Reset in mid-run with the flag up must drop it and the limits
		word = 16'h0000;
		send = 1;
		step();
		send = 0;
		repeat (2) step();
		cmp("flag before reset", 8'h01, {7'h00, flag});
		srst = 1;
		repeat (2) step();
		srst = 0;
		cmp("flag irq reset", 8'h00, {6'h00, flag, irq});
		cmp("rdData reset", 8'h00, rdData);
		rd(2'h0, 8'h00);
		rd(2'h1, 8'h00);
		rd(2'h2, 8'hff);
		rd(2'h3, 8'hff);
		diff = 0;
		left = 0;
		// Reset limits select outside mode with nothing outside
		chk(16'h03ff, 0);
		chk(16'h0000, 0);
		tally_and_finish();
	end
endmodule : adc_window_detector_limits_tb
